/* File: hdl/offset_cal_defines.svh */
/*
  Bit positions, field widths, power-on values and timing counts for the
  offset-loop control word and the stage 3 gain word.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef OFFSET_CAL_DEFINES_SVH
`define OFFSET_CAL_DEFINES_SVH

`define WORD_W            32
`define ADDR_W            5
`define ADDR_LOOP_CTRL    5'h1d
`define ADDR_GAIN_CTRL    5'h1e
`define BIT_RX_AUTOCAL    5
`define BIT_RX_LOOP_EN    17
`define BIT_XP_AUTOCAL    18
`define BIT_XP_PWD        31
`define BIT_RESERVED30    30
`define LSB_RX_DEMOD      6
`define LSB_RX_IMIX       8
`define LSB_RX_QMIX       10
`define LSB_RX_DAC        12
`define LSB_RX_CLKDIV     14
`define LSB_XP_DEMOD      19
`define LSB_XP_IMIX       21
`define LSB_XP_QMIX       23
`define LSB_XP_DAC        25
`define LSB_XP_CLKDIV     27
`define LSB_S3_RANGE      5
`define LSB_S3_MINGAIN    10
`define RST_DEMOD         2'h1
`define RST_MIX_BIAS      2'h2
`define RST_DAC_RANGE     2'h3
`define RST_CLKDIV        3'h4
`define RST_S3_RANGE      5'h1c
`define RST_S3_MINGAIN    4'h2
`define RST_LOOP_CTRL     32'h67493a5d
`define RST_GAIN_CTRL     32'h00000b9e
`define CAL_STEPS         6'h20

`endif

/* File: hdl/offset_cal_engine.sv */
/*
  One offset autocalibration sequencer: counts loop-clock ticks after a
  start request and pulses done. Loop clock is a divided enable of clock.
  Assumes start is a one-cycle pulse on the same clock.
*/
`timescale 1ns/100ps
`include "offset_cal_defines.svh"

module offset_cal_engine #(
  parameter logic [5:0] STEPS = `CAL_STEPS
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // Control
  input  wire logic                    start,
  input  wire logic                    power_down,
  input  wire offset_cal_pkg::clkdiv_t clkdiv,
  // Status
  output logic                         busy,
  output logic                         done,
  output logic                         loop_tick
);
  offset_cal_pkg::cal_state_e state;
  logic [7:0] div_cnt;
  logic [5:0] step_cnt;

  // Loop clock: one tick every 2**(clkdiv+1) cycles
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt   <= 8'h00;
      loop_tick <= 1'b0;
    end else if (power_down) begin
      div_cnt   <= 8'h00;
      loop_tick <= 1'b0;
    end else begin
      div_cnt   <= div_cnt + 8'h01;
      loop_tick <= (div_cnt[clkdiv] == 1'b1) && (div_cnt & ((8'h02 << clkdiv) - 8'h01))
                   == ((8'h02 << clkdiv) - 8'h01);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= offset_cal_pkg::CAL_IDLE;
      step_cnt <= 6'h00;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        offset_cal_pkg::CAL_IDLE: begin
          step_cnt <= 6'h00;
          if (start) begin
            state <= offset_cal_pkg::CAL_RUN;
          end
        end
        offset_cal_pkg::CAL_RUN: begin
          if (loop_tick) begin
            step_cnt <= step_cnt + 6'h01;
            if (step_cnt == STEPS - 6'h01) begin
              state <= offset_cal_pkg::CAL_DONE;
            end
          end
        end
        offset_cal_pkg::CAL_DONE: begin
          done  <= 1'b1;
          state <= offset_cal_pkg::CAL_IDLE;
        end
        default: state <= offset_cal_pkg::CAL_IDLE;
      endcase
    end
  end

  assign busy = (state != offset_cal_pkg::CAL_IDLE);

  chk_done_after_run: assert property (@(posedge clock)
    disable iff (sys_rst) done |-> $past(state) == offset_cal_pkg::CAL_DONE)
    else $error("done without finishing the run");
endmodule : offset_cal_engine

/* File: hdl/offset_cal_pkg.sv */
/*
  Types shared by the offset-loop register bank.
  Assumes the defines header for widths.
*/
package offset_cal_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_e;
  typedef logic [2:0] clkdiv_t;
endpackage : offset_cal_pkg

/* File: hdl/offset_cal_regs.sv */
/*
  Offset-loop control word and stage 3 gain word of the IF transceiver,
  loaded from a 32-bit serial programming word. Drives the correction
  loops statically and runs both autocalibrations.
  Assumes wr_valid/wr_word come from the serial port logic on clock.
*/
`timescale 1ns/100ps
`include "offset_cal_defines.svh"

module offset_cal_regs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Programming word from the serial port
  input  wire logic        wr_valid,
  input  wire logic [31:0] wr_word,
  // Register read-back
  output logic [31:0]      loop_ctrl_word,
  output logic [31:0]      gain_ctrl_word,
  // Rx correction loop
  output logic             rx_offset_loop_enable,
  output logic [1:0]       rx_correction_dac_range,
  output logic [2:0]       rx_loop_clock_divider,
  output logic             rx_cal_busy,
  output logic             rx_loop_tick,
  // Cross-polarization correction loop
  output logic             xpol_loop_power_down,
  output logic [1:0]       xpol_correction_dac_range,
  output logic [2:0]       xpol_loop_clock_divider,
  output logic             xpol_cal_busy,
  output logic             xpol_loop_tick,
  // Static demodulator and mixer settings
  output logic [1:0]       rx_demod_current,
  output logic [1:0]       rx_i_mixer_bias,
  output logic [1:0]       rx_q_mixer_bias,
  output logic [1:0]       xpol_demod_current,
  output logic [1:0]       xpol_i_mixer_bias,
  output logic [1:0]       xpol_q_mixer_bias,
  // Stage 3 gain
  output logic [4:0]       stage3_gain_range,
  output logic [3:0]       stage3_min_gain
);
  logic wr_loop;
  logic wr_gain;
  logic rx_offset_autocal_start;
  logic xpol_offset_autocal_start;
  logic rx_start_pulse;
  logic xp_start_pulse;
  logic rx_done;
  logic xp_done;
  logic rx_busy_i;
  logic xp_busy_i;
  logic rx_tick_i;
  logic xp_tick_i;

  assign wr_loop = wr_valid && (wr_word[4:0] == `ADDR_LOOP_CTRL);
  assign wr_gain = wr_valid && (wr_word[4:0] == `ADDR_GAIN_CTRL);
  assign rx_start_pulse = wr_loop && wr_word[`BIT_RX_AUTOCAL];
  assign xp_start_pulse = wr_loop && wr_word[`BIT_XP_AUTOCAL];

  // Static loop-control fields
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_demod_current          <= `RST_DEMOD;
      rx_i_mixer_bias           <= `RST_MIX_BIAS;
      rx_q_mixer_bias           <= `RST_MIX_BIAS;
      rx_correction_dac_range   <= `RST_DAC_RANGE;
      rx_loop_clock_divider     <= `RST_CLKDIV;
      rx_offset_loop_enable     <= 1'b0;
      xpol_demod_current        <= `RST_DEMOD;
      xpol_i_mixer_bias         <= `RST_MIX_BIAS;
      xpol_q_mixer_bias         <= `RST_MIX_BIAS;
      xpol_correction_dac_range <= `RST_DAC_RANGE;
      xpol_loop_clock_divider   <= `RST_CLKDIV;
      xpol_loop_power_down      <= 1'b0;
    end else if (wr_loop) begin
      rx_demod_current          <= wr_word[`LSB_RX_DEMOD +: 2];
      rx_i_mixer_bias           <= wr_word[`LSB_RX_IMIX +: 2];
      rx_q_mixer_bias           <= wr_word[`LSB_RX_QMIX +: 2];
      rx_correction_dac_range   <= wr_word[`LSB_RX_DAC +: 2];
      rx_loop_clock_divider     <= wr_word[`LSB_RX_CLKDIV +: 3];
      rx_offset_loop_enable     <= wr_word[`BIT_RX_LOOP_EN];
      xpol_demod_current        <= wr_word[`LSB_XP_DEMOD +: 2];
      xpol_i_mixer_bias         <= wr_word[`LSB_XP_IMIX +: 2];
      xpol_q_mixer_bias         <= wr_word[`LSB_XP_QMIX +: 2];
      xpol_correction_dac_range <= wr_word[`LSB_XP_DAC +: 2];
      xpol_loop_clock_divider   <= wr_word[`LSB_XP_CLKDIV +: 3];
      xpol_loop_power_down      <= wr_word[`BIT_XP_PWD];
    end
  end

  // Start bits: a new write setting the bit wins over a done in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_offset_autocal_start <= 1'b0;
    end else if (rx_start_pulse) begin
      rx_offset_autocal_start <= 1'b1;
    end else if (rx_done) begin
      rx_offset_autocal_start <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      xpol_offset_autocal_start <= 1'b0;
    end else if (xp_start_pulse) begin
      xpol_offset_autocal_start <= 1'b1;
    end else if (xp_done) begin
      xpol_offset_autocal_start <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage3_gain_range <= `RST_S3_RANGE;
      stage3_min_gain   <= `RST_S3_MINGAIN;
    end else if (wr_gain) begin
      stage3_gain_range <= wr_word[`LSB_S3_RANGE +: 5];
      stage3_min_gain   <= wr_word[`LSB_S3_MINGAIN +: 4];
    end
  end

  offset_cal_engine u_rx_cal (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .start      (rx_start_pulse),
    .power_down (1'b0),
    .clkdiv     (rx_loop_clock_divider),
    .busy       (rx_busy_i),
    .done       (rx_done),
    .loop_tick  (rx_tick_i)
  );

  // Cross-pol loop clock halts while powered down
  offset_cal_engine u_xp_cal (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .start      (xp_start_pulse),
    .power_down (xpol_loop_power_down),
    .clkdiv     (xpol_loop_clock_divider),
    .busy       (xp_busy_i),
    .done       (xp_done),
    .loop_tick  (xp_tick_i)
  );

  // Registered status and read-back
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cal_busy    <= 1'b0;
      xpol_cal_busy  <= 1'b0;
      rx_loop_tick   <= 1'b0;
      xpol_loop_tick <= 1'b0;
      loop_ctrl_word <= `RST_LOOP_CTRL;
      gain_ctrl_word <= `RST_GAIN_CTRL;
    end else begin
      rx_cal_busy    <= rx_busy_i;
      xpol_cal_busy  <= xp_busy_i;
      rx_loop_tick   <= rx_tick_i && rx_offset_loop_enable;
      xpol_loop_tick <= xp_tick_i;
      // Bit 30 has no storage behind it and always reads one
      loop_ctrl_word <= {xpol_loop_power_down, 1'b1, xpol_loop_clock_divider,
                         xpol_correction_dac_range, xpol_q_mixer_bias,
                         xpol_i_mixer_bias, xpol_demod_current,
                         xpol_offset_autocal_start, rx_offset_loop_enable,
                         rx_loop_clock_divider, rx_correction_dac_range,
                         rx_q_mixer_bias, rx_i_mixer_bias, rx_demod_current,
                         rx_offset_autocal_start, `ADDR_LOOP_CTRL};
      gain_ctrl_word <= {18'h00000, stage3_min_gain, stage3_gain_range, `ADDR_GAIN_CTRL};
    end
  end

  chk_rx_start_set: assert property (@(posedge clock) disable iff (sys_rst)
    rx_start_pulse |=> rx_offset_autocal_start)
    else $error("rx autocal bit not set by write");
  chk_rx_clear_done: assert property (@(posedge clock) disable iff (sys_rst)
    (rx_done && !rx_start_pulse) |=> !rx_offset_autocal_start)
    else $error("rx autocal bit not cleared at done");
  chk_xp_clear_done: assert property (@(posedge clock) disable iff (sys_rst)
    (xp_done && !xp_start_pulse) |=> !xpol_offset_autocal_start)
    else $error("xpol autocal bit not cleared at done");
  chk_xp_pwd_tick: assert property (@(posedge clock) disable iff (sys_rst)
    xpol_loop_power_down |-> ##2 !xpol_loop_tick)
    else $error("xpol loop ticks while powered down");
  chk_rx_div_load: assert property (@(posedge clock) disable iff (sys_rst)
    wr_loop |=> rx_loop_clock_divider == $past(wr_word[16:14]))
    else $error("rx divider not loaded");
  chk_xp_div_load: assert property (@(posedge clock) disable iff (sys_rst)
    wr_loop |=> xpol_loop_clock_divider == $past(wr_word[29:27]))
    else $error("xpol divider not loaded");
  chk_rx_en_load: assert property (@(posedge clock) disable iff (sys_rst)
    wr_loop |=> rx_offset_loop_enable == $past(wr_word[17]))
    else $error("rx loop enable not loaded");
  chk_gain_load: assert property (@(posedge clock) disable iff (sys_rst)
    wr_gain |=> stage3_gain_range == $past(wr_word[9:5])
      && stage3_min_gain == $past(wr_word[13:10]))
    else $error("stage 3 gain not loaded");
  chk_gain_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !wr_gain |=> $stable(stage3_gain_range))
    else $error("stage 3 gain changed without its address");
  chk_dac_load: assert property (@(posedge clock) disable iff (sys_rst)
    wr_loop |=> rx_correction_dac_range == $past(wr_word[13:12])
      && xpol_correction_dac_range == $past(wr_word[26:25]))
    else $error("dac range not loaded");

  cov_rx_cal: cover property (@(posedge clock) rx_start_pulse ##[1:1000] rx_done);
  cov_xp_cal: cover property (@(posedge clock) xp_start_pulse ##[1:1000] xp_done);
  cov_gain_wr: cover property (@(posedge clock) wr_gain);
endmodule : offset_cal_regs

/* File: sim/serial_host_model.sv */
/*
  Serial host controller model: hands whole 32-bit programming words to
  the register bank, one word per write.
  Assumes the bank samples wr_valid and wr_word on the rising clock edge.
*/
`timescale 1ns/100ps

module serial_host_model (
  // Clock
  input  wire logic        clock,
  // Programming word
  output logic             wr_valid,
  output logic [31:0]      wr_word
);
  initial begin
    wr_valid = 1'b0;
    wr_word  = 32'h0;
  end

  // Word is inverted once released, so a stale word never looks like a fresh one
  task automatic write_word(input logic [31:0] word);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_word  <= word;
    @(posedge clock);
    wr_valid <= 1'b0;
    wr_word  <= ~word;
  endtask : write_word
endmodule : serial_host_model

/* File: sim/tb_dc_offset_cal_config_regs.sv */
/*
  Self-checking bench for the offset-loop register bank: power-on values,
  field writes, refused addresses, autocalibration, loop ticks, reset mid-run.
  Assumes the serial host model delivers whole programming words.
*/
`timescale 1ns/100ps
`include "offset_cal_defines.svh"

module tb_dc_offset_cal_config_regs;
  typedef struct packed {
    logic [31:0] word;
    logic [31:0] el;
    logic [31:0] eg;
  } row_s;

  logic        clock;
  logic        sys_rst;
  logic        wr_valid;
  logic [31:0] wr_word;
  logic [31:0] loop_ctrl_word, gain_ctrl_word;
  logic        rx_offset_loop_enable, rx_cal_busy, rx_loop_tick;
  logic        xpol_loop_power_down, xpol_cal_busy, xpol_loop_tick;
  logic [1:0]  rx_correction_dac_range, xpol_correction_dac_range;
  logic [2:0]  rx_loop_clock_divider, xpol_loop_clock_divider;
  logic [1:0]  rx_demod_current, rx_i_mixer_bias, rx_q_mixer_bias;
  logic [1:0]  xpol_demod_current, xpol_i_mixer_bias, xpol_q_mixer_bias;
  logic [4:0]  stage3_gain_range;
  logic [3:0]  stage3_min_gain;
  row_s        rows [5];
  int          mismatches;
  int          n_compared;

  serial_host_model host (.clock(clock), .wr_valid(wr_valid), .wr_word(wr_word));

  offset_cal_regs dut (
    .clock(clock), .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_word(wr_word),
    .loop_ctrl_word(loop_ctrl_word), .gain_ctrl_word(gain_ctrl_word),
    .rx_offset_loop_enable(rx_offset_loop_enable), .rx_cal_busy(rx_cal_busy),
    .rx_correction_dac_range(rx_correction_dac_range), .rx_loop_tick(rx_loop_tick),
    .rx_loop_clock_divider(rx_loop_clock_divider), .xpol_cal_busy(xpol_cal_busy),
    .xpol_loop_power_down(xpol_loop_power_down), .xpol_loop_tick(xpol_loop_tick),
    .xpol_correction_dac_range(xpol_correction_dac_range),
    .xpol_loop_clock_divider(xpol_loop_clock_divider),
    .rx_demod_current(rx_demod_current), .rx_i_mixer_bias(rx_i_mixer_bias),
    .rx_q_mixer_bias(rx_q_mixer_bias), .xpol_demod_current(xpol_demod_current),
    .xpol_i_mixer_bias(xpol_i_mixer_bias), .xpol_q_mixer_bias(xpol_q_mixer_bias),
    .stage3_gain_range(stage3_gain_range), .stage3_min_gain(stage3_min_gain)
  );

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Every field output is compared with the slice of the expected word
  task automatic check_fields(input logic [31:0] el, input logic [31:0] eg);
    check("loop_ctrl_word", loop_ctrl_word, el);
    check("gain_ctrl_word", gain_ctrl_word, eg);
    check("rx_bias", 32'({rx_demod_current, rx_i_mixer_bias, rx_q_mixer_bias}),
          32'({el[7:6], el[9:8], el[11:10]}));
    check("xpol_bias", 32'({xpol_demod_current, xpol_i_mixer_bias, xpol_q_mixer_bias}),
          32'({el[20:19], el[22:21], el[24:23]}));
    check("rx_dac_range", 32'(rx_correction_dac_range), 32'(el[13:12]));
    check("xpol_dac_range", 32'(xpol_correction_dac_range), 32'(el[26:25]));
    check("rx_divider", 32'(rx_loop_clock_divider), 32'(el[16:14]));
    check("xpol_divider", 32'(xpol_loop_clock_divider), 32'(el[29:27]));
    check("rx_loop_enable", 32'(rx_offset_loop_enable), 32'(el[17]));
    check("xpol_power_down", 32'(xpol_loop_power_down), 32'(el[31]));
    check("stage3", 32'({stage3_gain_range, stage3_min_gain}),
          32'({eg[9:5], eg[13:10]}));
  endtask : check_fields

  // A zero write in mid-run must not cut the calibration short
  task automatic autocal(input logic [31:0] w, input int bitpos, input logic xp);
    int n;
    host.write_word(w);
    repeat (3) @(negedge clock);
    check("autocal bit", 32'(loop_ctrl_word[bitpos]), 32'h1);
    check("cal_busy", 32'(xp ? xpol_cal_busy : rx_cal_busy), 32'h1);
    host.write_word(w & ~(32'h1 << bitpos));
    @(negedge clock);
    check("cal_busy held", 32'(xp ? xpol_cal_busy : rx_cal_busy), 32'h1);
    n = 0;
    while ((xp ? xpol_cal_busy : rx_cal_busy) !== 1'b0 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    if (n == 5000) begin
      mismatches++;
      results();
    end
    repeat (4) @(negedge clock);
    check("autocal cleared", loop_ctrl_word,
          (w & ~(32'h1 << bitpos)) | 32'h40000000);
  endtask : autocal

  // With divider 000 a loop tick comes every 2 cycles
  task automatic ticks(input logic [31:0] w, input int exp_rx, input int exp_xp);
    int nr;
    int nx;
    nr = 0;
    nx = 0;
    host.write_word(w);
    repeat (4) @(negedge clock);
    repeat (40) begin
      @(negedge clock);
      nr += int'(rx_loop_tick === 1'b1);
      nx += int'(xpol_loop_tick === 1'b1);
    end
    check("rx_loop_tick count", 32'(nr), 32'(exp_rx));
    check("xpol_loop_tick count", 32'(nx), 32'(exp_xp));
  endtask : ticks

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    mismatches = 0;
    n_compared = 0;
    // Last two rows carry wrong addresses and must leave both words alone
    rows = '{'{32'h0000001d, 32'h4000001d, `RST_GAIN_CTRL},
             '{32'hbffbffdd, 32'hfffbffdd, `RST_GAIN_CTRL},
             '{32'hffff26be, 32'hfffbffdd, 32'h000026be},
             '{32'h0000001c, 32'hfffbffdd, 32'h000026be},
             '{32'hfffffff5, 32'hfffbffdd, 32'h000026be}};
    sys_rst = 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check("rx_cal_busy", 32'(rx_cal_busy), 32'h0);
    check_fields(`RST_LOOP_CTRL, `RST_GAIN_CTRL);
    $display("test power_on done");
    foreach (rows[i]) begin
      host.write_word(rows[i].word);
      repeat (3) @(negedge clock);
      check_fields(rows[i].el, rows[i].eg);
    end
    $display("test field_rows done");
    autocal(32'h0000003d, 5, 1'b0);
    autocal(32'h0004001d, 18, 1'b1);
    $display("test autocal done");
    ticks(32'h0002001d, 20, 20);
    // Divider 001 on both loops: one tick every 4 cycles
    ticks(32'h0802401d, 10, 10);
    ticks(32'h8002001d, 20, 0);
    ticks(32'h8000001d, 0, 0);
    $display("test loop_ticks done");
    host.write_word(32'h0004003d);
    repeat (3) @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check("busy after reset", 32'({rx_cal_busy, xpol_cal_busy}), 32'h0);
    check_fields(`RST_LOOP_CTRL, `RST_GAIN_CTRL);
    $display("test mid_run_reset done");
    results();
  end
endmodule : tb_dc_offset_cal_config_regs
